/* rosc_defines.vh */
`ifndef ROSC_DEFINES_VH
`define ROSC_DEFINES_VH
// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define ROSC_IDX_ON        18'h04078
`define ROSC_IDX_SLEEP     18'h04079
`define ROSC_IDX_HWCTL     18'h0407C
`define ROSC_IDX_STATUS    18'h0407D
`define ROSC_ADDR_W        18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ROSC_SLOT_HI       15
`define ROSC_SLOT_LO       13
`define ROSC_MODE_BIT      8
`define ROSC_VSEL_HI       4
`define ROSC_VSEL_LO       0
`define ROSC_HWVSEL_BIT    10
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ROSC_ON_RESET      16'h0000
`define ROSC_SLEEP_RESET   16'h0100
`define ROSC_HWCTL_RESET   16'h0000
`define ROSC_ON_MASK       16'hE11F
`define ROSC_HWCTL_MASK    16'h0400
`define ROSC_SLOT_HW1      3'h6
`define ROSC_SLOT_HW2      3'h7
`define ROSC_SLOT_OFF      3'h0
`define ROSC_VSTEP_KNEE    5'h0E
`define ROSC_MV_BASE_LO    12'h384
`define ROSC_MV_STEP_LO    12'h032
`define ROSC_MV_BASE_HI    12'h6A4
`define ROSC_MV_STEP_HI    12'h064
`define ROSC_RESP_OKAY     2'h0
`define ROSC_RESP_SLVERR   2'h2
`endif

/* rosc_regs.v */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rosc_defines.vh"

module rosc_regs (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire [17:0] awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output reg         awready,
  // Write data channel
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // Write response channel
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // Read address channel
  input  wire [17:0] araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output reg         arready,
  // Read data channel
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Sequencer timeslot events
  input  wire        startup_slot_pulse,
  input  wire        sleep_slot_pulse,
  input  wire [2:0]  slot_number,
  // Hardware enable inputs
  input  wire        hw_enable_1,
  input  wire        hw_enable_2,
  // Channel controls to the regulator
  output reg         channel_enable,
  output reg         channel_sleep,
  output reg         channel_low_power,
  output reg  [4:0]  channel_voltage_code,
  output reg  [11:0] channel_millivolts
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Voltage code to millivolts, two step ranges
  function [11:0] code_to_mv;
    input [4:0] code;
    begin
      if (code <= `ROSC_VSTEP_KNEE) begin
        code_to_mv = `ROSC_MV_BASE_LO + `ROSC_MV_STEP_LO * {7'h00, code};
      end else begin
        code_to_mv = `ROSC_MV_BASE_HI
                   + `ROSC_MV_STEP_HI * {7'h00, code - 5'h0F};
      end
    end
  endfunction

  // Byte address to register index
  function [17:0] addr_index;
    input [17:0] addr;
    begin
      addr_index = {2'h0, addr[17:2]};
    end
  endfunction

  // Sleep slot code to the timeslot in which it acts
  function [2:0] sleep_slot_of;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        sleep_slot_of = 3'h5;
      end else if (code == 3'h6) begin
        sleep_slot_of = 3'h3;
      end else if (code == 3'h7) begin
        sleep_slot_of = 3'h1;
      end else begin
        sleep_slot_of = 3'h6 - code;
      end
    end
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [15:0] mask;
    begin
      merge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge[15:8] = strb[1] ? data[15:8] : old[15:8];
      merge       = merge & mask;
    end
  endfunction

  // ----------------------------------------
  // Registers and field views
  // ----------------------------------------
  reg  [15:0] on_ctrl;
  reg  [15:0] sleep_ctrl;
  reg  [15:0] hw_ctrl;
  reg  [17:0] aw_addr_held;
  reg  [31:0] w_data_held;
  reg  [3:0]  w_strb_held;
  reg         aw_held;
  reg         w_held;
  reg         asleep;

  wire [2:0] on_timeslot_select    = on_ctrl[`ROSC_SLOT_HI:`ROSC_SLOT_LO];
  wire       on_power_mode         = on_ctrl[`ROSC_MODE_BIT];
  wire [4:0] on_voltage_code       = on_ctrl[`ROSC_VSEL_HI:`ROSC_VSEL_LO];
  wire [2:0] sleep_timeslot_select = sleep_ctrl[`ROSC_SLOT_HI:`ROSC_SLOT_LO];
  wire       sleep_power_mode      = sleep_ctrl[`ROSC_MODE_BIT];
  wire [4:0] sleep_voltage_code    = sleep_ctrl[`ROSC_VSEL_HI:`ROSC_VSEL_LO];
  wire       hw_control_voltage_choice = hw_ctrl[`ROSC_HWVSEL_BIT];

  wire       hw_mode  = (on_timeslot_select == `ROSC_SLOT_HW1)
                     || (on_timeslot_select == `ROSC_SLOT_HW2);
  wire       hw_level = (on_timeslot_select == `ROSC_SLOT_HW1)
                     ? hw_enable_1 : hw_enable_2;
  wire       sleep_disables = (sleep_timeslot_select != 3'h0)
                           && (sleep_timeslot_select < 3'h6);
  wire       sleep_hit = sleep_slot_pulse
                      && (slot_number == sleep_slot_of(sleep_timeslot_select));
  wire       on_hit    = startup_slot_pulse && (slot_number == on_timeslot_select);
  wire       aw_fire   = awvalid && awready;
  wire       w_fire    = wvalid && wready;
  wire       ar_fire   = arvalid && arready;
  wire       do_write  = aw_held && w_held && !bvalid;
  wire [17:0] w_index  = addr_index(aw_addr_held);
  wire [17:0] r_index  = addr_index(araddr);

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  // Address and data latch independently; response follows both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready      <= 1'b0;
      wready       <= 1'b0;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_held <= 18'h00000;
      w_data_held  <= 32'h00000000;
      w_strb_held  <= 4'h0;
      bvalid       <= 1'b0;
      bresp        <= `ROSC_RESP_OKAY;
    end else begin
      if (!aw_held && !awready && !bvalid) begin
        awready <= 1'b1;
      end else if (aw_fire) begin
        awready      <= 1'b0;
        aw_held      <= 1'b1;
        aw_addr_held <= awaddr;
      end
      if (!w_held && !wready && !bvalid) begin
        wready <= 1'b1;
      end else if (w_fire) begin
        wready      <= 1'b0;
        w_held      <= 1'b1;
        w_data_held <= wdata;
        w_strb_held <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        if (w_index == `ROSC_IDX_ON || w_index == `ROSC_IDX_SLEEP
            || w_index == `ROSC_IDX_HWCTL || w_index == `ROSC_IDX_STATUS) begin
          bresp <= `ROSC_RESP_OKAY;
        end else begin
          bresp <= `ROSC_RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register writes; status is read only
  always @(posedge aclk) begin
    if (!aresetn) begin
      on_ctrl    <= `ROSC_ON_RESET;
      sleep_ctrl <= `ROSC_SLEEP_RESET;
      hw_ctrl    <= `ROSC_HWCTL_RESET;
    end else if (do_write) begin
      if (w_index == `ROSC_IDX_ON) begin
        on_ctrl <= merge(on_ctrl, w_data_held, w_strb_held, `ROSC_ON_MASK);
      end else if (w_index == `ROSC_IDX_SLEEP) begin
        sleep_ctrl <= merge(sleep_ctrl, w_data_held, w_strb_held, `ROSC_ON_MASK);
      end else if (w_index == `ROSC_IDX_HWCTL) begin
        hw_ctrl <= merge(hw_ctrl, w_data_held, w_strb_held, `ROSC_HWCTL_MASK);
      end
    end
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  // One read in flight; data captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `ROSC_RESP_OKAY;
    end else if (ar_fire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `ROSC_RESP_OKAY;
      if (r_index == `ROSC_IDX_ON) begin
        rdata <= {16'h0000, on_ctrl};
      end else if (r_index == `ROSC_IDX_SLEEP) begin
        rdata <= {16'h0000, sleep_ctrl};
      end else if (r_index == `ROSC_IDX_HWCTL) begin
        rdata <= {16'h0000, hw_ctrl};
      end else if (r_index == `ROSC_IDX_STATUS) begin
        rdata <= {24'h000000, channel_voltage_code,
                  channel_low_power, channel_sleep, channel_enable};
      end else begin
        rdata <= 32'h00000000;
        rresp <= `ROSC_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Channel sequencing
  // ----------------------------------------
  // Enable and sleep state from timeslot events; in hardware mode enable follows the hardware enable input
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_enable <= 1'b0;
      asleep         <= 1'b0;
    end else if (hw_mode) begin
      channel_enable <= hw_level;
      if (sleep_hit) begin
        asleep <= 1'b1;
      end else if (startup_slot_pulse && slot_number == 3'h1) begin
        asleep <= 1'b0;
      end
    end else if (on_timeslot_select == `ROSC_SLOT_OFF) begin
      channel_enable <= 1'b0;
      asleep         <= 1'b0;
    end else if (on_hit) begin
      channel_enable <= 1'b1;
      asleep         <= 1'b0;
    end else if (sleep_hit && sleep_disables) begin
      channel_enable <= 1'b0;
      asleep         <= 1'b0;
    end else if (sleep_hit) begin
      asleep <= 1'b1;
    end
  end

  // ----------------------------------------
  // Operating point
  // ----------------------------------------
  // Mode and voltage follow the state; hardware control picks the voltage by choice bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_sleep        <= 1'b0;
      channel_low_power    <= 1'b0;
      channel_voltage_code <= 5'h00;
      channel_millivolts   <= `ROSC_MV_BASE_LO;
    end else begin
      channel_sleep     <= asleep;
      channel_low_power <= asleep ? sleep_power_mode : on_power_mode;
      if (hw_mode) begin
        channel_voltage_code <= hw_control_voltage_choice
                              ? sleep_voltage_code : on_voltage_code;
        channel_millivolts   <= code_to_mv(hw_control_voltage_choice
                              ? sleep_voltage_code : on_voltage_code);
      end else begin
        channel_voltage_code <= asleep ? sleep_voltage_code : on_voltage_code;
        channel_millivolts   <= code_to_mv(asleep ? sleep_voltage_code
                                                  : on_voltage_code);
      end
    end
  end

endmodule // rosc_regs

/* rosc_regs_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bus and channel checks
// ----------------------------------------
module rosc_regs_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  // Read handshakes and data
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Sequencer and channel
  input wire logic        startup_slot_pulse,
  input wire logic        hw_enable_1,
  input wire logic        hw_enable_2,
  input wire logic        channel_enable,
  input wire logic [4:0]  channel_voltage_code,
  input wire logic [11:0] channel_millivolts
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake steps of a transfer
  sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence rd_taken; arvalid && arready; endsequence
  // Held address and data commit one edge after the handshake, response on that same edge
  wr_resp_a: assert property (wr_taken |-> ##2 bvalid) else $error("no write response");
  aw_block_a: assert property (wr_taken |=> !awready [*2]) else $error("write not refused");
  b_done_a: assert property (bvalid && bready |=> !bvalid ##1 awready && wready)
    else $error("write channel not reopened");
  rd_resp_a: assert property (rd_taken |=> rvalid && !arready) else $error("no read data");
  r_done_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");
  r_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("undefined bits set");
  mv_low_a: assert property (channel_voltage_code <= 5'h0E |->
    channel_millivolts == 900 + 50 * channel_voltage_code) else $error("low step wrong");
  mv_high_a: assert property (channel_voltage_code >= 5'h0F |->
    channel_millivolts == 1700 + 100 * (channel_voltage_code - 15))
    else $error("high step wrong");
  en_cause_a: assert property ($rose(channel_enable) |->
    $past(startup_slot_pulse) || $past(hw_enable_1) || $past(hw_enable_2))
    else $error("enable without cause");
endmodule // rosc_regs_asserts

/* test_rosc_regs.sv */
`timescale 1ns/1ps
module test_rosc_regs;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, st_p = 1'b0, sl_p = 1'b0, hw1 = 1'b0, hw2 = 1'b0;
  reg  [17:0] awaddr = 18'h00000, araddr = 18'h00000;
  reg  [31:0] wdata = 32'h00000000, d;
  reg  [2:0]  slot = 3'h0;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid, en, slp, lp;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [4:0]  vc;
  wire [11:0] mv;
  integer     failures = 0, compares = 0, cyc = 0, i, s, m, v, w;
  int         sl [8] = '{5, 5, 4, 3, 2, 1, 3, 1};
  localparam [17:0] ON = 18'h101E0, SLP = 18'h101E4, HWC = 18'h101F0, STS = 18'h101F4;

  rosc_regs rosc_regs_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .startup_slot_pulse(st_p), .sleep_slot_pulse(sl_p),
    .slot_number(slot), .hw_enable_1(hw1), .hw_enable_2(hw2), .channel_enable(en),
    .channel_sleep(slp), .channel_low_power(lp), .channel_voltage_code(vc),
    .channel_millivolts(mv));

  // Free-running clock
  initial forever #20 aclk = ~aclk;

  // Cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      final_report;
    end
  end

  // ----------------------------------------
  // Bus, sequencer and comparison tasks
  // ----------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Address and data offered together, each released once taken
  task wr(input [17:0] a, input [31:0] dd);
    @(posedge aclk);
    awaddr <= a; wdata <= dd; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    #1;
    while (awvalid || wvalid) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      #1;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input [17:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    #1;
    while (arvalid) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      #1;
    end
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Outputs follow a cause within two edges
  task settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task pulse(input st, input [2:0] n);
    @(posedge aclk);
    slot <= n; st_p <= st; sl_p <= !st;
    @(posedge aclk);
    st_p <= 1'b0; sl_p <= 1'b0;
    settle;
  endtask

  function int mvx(int c);
    return c <= 14 ? 900 + 50 * c : 1700 + 100 * (c - 15);
  endfunction

  task final_report;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(14));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ON); chk(d, 32'h0000);
    rd(SLP); chk(d, 32'h0100);
    rd(18'h00100); chk(r, 2'h2); chk(d, 32'h0);
    wr(18'h00100, 32'hFFFF);
    chk(r, 2'h2);
    // Undefined bits never stick
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : $urandom;
      wr(i[0] ? SLP : ON, v); rd(i[0] ? SLP : ON); chk(d, v & 32'h0000E11F);
    end
    // Each start-up slot, with a wrong slot first
    for (i = 1; i <= 5; i++) begin
      wr(ON, 32'h0); pulse(1, 3'h1); chk(en, 1'b0);
      wr(ON, i << 13); pulse(1, i % 5 + 1); chk(en, 1'b0);
      pulse(1, i[2:0]); chk(en, 1'b1);
    end
    for (i = 0; i < 32; i++) begin
      m = $urandom % 2;
      wr(ON, 32'h2000 | m << 8 | i); pulse(1, 3'h1);
      chk(vc, i); chk(mv, mvx(i)); chk(lp, m);
    end
    // Every sleep code at its own slot
    for (s = 0; s < 8; s++) begin
      v = $urandom % 32; m = $urandom % 2;
      wr(SLP, s << 13 | m << 8 | v); wr(ON, 32'h2000); pulse(1, 3'h1);
      pulse(0, sl[s]);
      if (s >= 1 && s <= 5) chk(en, 1'b0);
      else begin
        chk(slp, 1'b1); chk(vc, v); chk(lp, m); chk(mv, mvx(v));
        rd(STS);
        chk(d, v << 3 | m << 2 | 3);
      end
    end
    // Hardware enable inputs, voltage choice, sleep entry
    for (s = 0; s < 2; s++) begin
      v = $urandom % 32; w = $urandom % 32;
      wr(SLP, 32'h4000 | w); wr(ON, (6 + s) << 13 | v);
      // Start-up slot one wakes the channel, so the later sleep entry is a real change
      pulse(1, 3'h1);
      chk(slp, 1'b0);
      for (i = 0; i < 9; i++) begin
        m = (i == 8) ? 1 : $urandom % 2;
        @(posedge aclk);
        if (s) hw2 <= m[0]; else hw1 <= m[0];
        @(posedge aclk); #1; chk(en, m);
      end
      wr(HWC, 32'h400); settle; chk(vc, w);
      chk(r, 2'h0);
      wr(HWC, 32'h0); settle; chk(vc, v);
      pulse(0, 3'h4); chk(slp, 1'b1); chk(en, 1'b1);
    end
    // Reset in mid-run brings registers and channel back to their reset state
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(en, 1'b0);
    chk(slp, 1'b0);
    chk(mv, 900);
    rd(SLP);
    chk(d, 32'h0100);
    rd(ON);
    chk(d, 32'h0000);
    final_report;
  end
endmodule // test_rosc_regs

bind rosc_regs rosc_regs_asserts rosc_regs_asserts_inst (.*);
